// File: core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // ------------------------------------------------------------
  // register word indices on the local register port
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL    = 4'h0;
  localparam logic [3:0] OFS_CFG_FIRST  = 4'h1;
  localparam logic [3:0] OFS_CFG_SECOND = 4'h4;
  localparam logic [3:0] OFS_DATA       = 4'h7;
  localparam logic [3:0] OFS_PRESCALER  = 4'ha;
  // ------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------
  localparam int START_LSB = 0;
  localparam int SE_LSB    = 4;
  localparam int BUSY_BIT  = 15;
  // ------------------------------------------------------------
  // first configuration word fields
  // ------------------------------------------------------------
  localparam int GAIN_LSB = 0;
  localparam int RES_LSB  = 5;
  localparam int CO_LSB   = 8;
  // ------------------------------------------------------------
  // second configuration word fields
  // ------------------------------------------------------------
  localparam int BIAS_LSB = 0;
  localparam int REF_LSB  = 4;
  // ------------------------------------------------------------
  // channels and reference sources
  // ------------------------------------------------------------
  localparam logic [1:0] CH_ONE  = 2'h0;
  localparam logic [1:0] CH_TWO  = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  localparam logic [1:0] REF_SUPPLY   = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_BANDGAP  = 2'h2;
  // ------------------------------------------------------------
  // converter timing
  // ------------------------------------------------------------
  localparam logic [9:0] PRESC_MIN   = 10'h004;
  localparam logic [9:0] PRESC_MAX   = 10'h200;
  localparam logic [4:0] RES_MIN_BITS = 5'h09;
  localparam logic [4:0] RES_FULL_BITS = 5'h10;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_e;
endpackage : adc_ctrl_pkg

// File: core/adc_ctrl.sv
`timescale 1ns/100ps
// Contract
// - writing a start bit of any channel to control begins a conversion
// - cpu clock is stopped for the whole conversion
// - all three start bits clear when conversion completes
// - result is latched into the converted channel's data register
// - cpu clock enable returns after latching and clearing
// - single-ended select field routes an input to channel one or two
// - some single-ended codes force fixed 0.7 gain, others use channel gain
// - per-channel 3-bit field selects 9 to 16 bit resolution
// - converter clocks per conversion grow with resolution
// - converter clock is system clock divided by 4 to 512
// - duration equals converter clocks per conversion over converter rate
// - coarse offset applies to differential and temperature channels
// - bias field selects fraction of bias; lower bias lengthens conversion
// - differential channels select supply, external or bandgap reference
// - temperature channel always uses bandgap reference
// - results are 16-bit two's complement
// - three channels, each with two config words and one data word
module adc_ctrl #(
  parameter logic [15:0] FIXED_GAIN_SE_MASK = 16'hff00
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // cpu clock gate
  output logic             cpu_clk_en,
  // modulator side
  output logic             adc_clk,
  output logic             mod_enable,
  output logic      [1:0]  mod_channel,
  output logic      [3:0]  mod_single_ended_select,
  output logic      [4:0]  mod_gain,
  output logic             mod_fixed_gain,
  output logic      [7:0]  mod_coarse_offset,
  output logic      [1:0]  mod_reference_select,
  output logic      [2:0]  mod_bias_fraction_select,
  input  wire logic        mod_bit
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    adc_ctrl_pkg::conv_state_e st;
    logic [2:0]          start;
    logic [3:0]          se;
    // settings and results of all three channels
    logic [2:0][15:0]    cfg_a;
    logic [2:0][15:0]    cfg_b;
    logic [2:0][15:0]    data;
    logic [9:0]          div;
    logic [9:0]          div_cnt;
    logic                clk_out;
    logic [1:0]          ch;
    logic [4:0]          nbits;
    logic [17:0]         base;
    logic [17:0]         remain;
    logic signed [17:0]  acc;
    logic [15:0]         rdata;
  } state_s;

  state_s q_r;
  state_s q_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // clip to the 16-bit two's complement range
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff)
      sat16 = 16'h7fff;
    else if (v < -18'sh08000)
      sat16 = 16'h8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // lowest channel wins when several start bits are set
  function automatic logic [1:0] pick_channel(input logic [2:0] s);
    if (s[0])
      pick_channel = adc_ctrl_pkg::CH_ONE;
    else if (s[1])
      pick_channel = adc_ctrl_pkg::CH_TWO;
    else
      pick_channel = adc_ctrl_pkg::CH_TEMP;
  endfunction : pick_channel

  // divisors outside the legal range are pulled to the nearest end
  function automatic logic [9:0] clamp_div(input logic [15:0] w);
    if (w < 16'(adc_ctrl_pkg::PRESC_MIN))
      clamp_div = adc_ctrl_pkg::PRESC_MIN;
    else if (w > 16'(adc_ctrl_pkg::PRESC_MAX))
      clamp_div = adc_ctrl_pkg::PRESC_MAX;
    else
      clamp_div = w[9:0];
  endfunction : clamp_div

  // true when the word index lies in [lo, hi)
  function automatic logic in_window(input logic [3:0] a, input logic [3:0] lo, input logic [3:0] hi);
    in_window = (a >= lo) && (a < hi);
  endfunction : in_window

  // ------------------------------------------------------------
  // decode of the settings of the active channel
  // ------------------------------------------------------------
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic [1:0]  ref_raw;
  logic        is_temp;

  always_comb
  begin
    act_a   = q_r.cfg_a[q_r.ch];
    act_b   = q_r.cfg_b[q_r.ch];
    is_temp = (q_r.ch == adc_ctrl_pkg::CH_TEMP);
    ref_raw = act_b[adc_ctrl_pkg::REF_LSB +: 2];
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic              tick;
  logic [1:0]        new_ch;
  logic [15:0]       new_a;
  logic [15:0]       new_b;
  logic [4:0]        new_bits;
  logic [17:0]       new_base;
  logic [17:0]       new_total;
  logic signed [17:0] scaled;

  always_comb
  begin
    q_nxt     = q_r;
    new_ch    = pick_channel(reg_wdata[adc_ctrl_pkg::START_LSB +: 3]);
    new_a     = q_r.cfg_a[new_ch];
    new_b     = q_r.cfg_b[new_ch];
    new_bits  = adc_ctrl_pkg::RES_MIN_BITS + {2'h0, new_a[adc_ctrl_pkg::RES_LSB +: 3]};
    new_base  = 18'h00001 << new_bits;
    // lower bias lengthens the run
    // 18 bits hold the longest run: full resolution at the lowest bias
    new_total = new_base + 18'((new_base >> 2) * new_b[adc_ctrl_pkg::BIAS_LSB +: 3]);
    scaled    = q_r.acc <<< (adc_ctrl_pkg::RES_FULL_BITS - q_r.nbits);

    // ------------------------------------------------------------
    // converter clock divider
    // ------------------------------------------------------------
    // converter clock divider
    tick = (q_r.div_cnt == q_r.div - 10'h001);
    if (tick)
      q_nxt.div_cnt = 10'h000;
    else
      q_nxt.div_cnt = q_r.div_cnt + 10'h001;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (reg_wr)
    begin
      if (in_window(reg_addr, adc_ctrl_pkg::OFS_CFG_FIRST, adc_ctrl_pkg::OFS_CFG_SECOND))
        q_nxt.cfg_a[2'(reg_addr - adc_ctrl_pkg::OFS_CFG_FIRST)] = reg_wdata;
      if (in_window(reg_addr, adc_ctrl_pkg::OFS_CFG_SECOND, adc_ctrl_pkg::OFS_DATA))
        q_nxt.cfg_b[2'(reg_addr - adc_ctrl_pkg::OFS_CFG_SECOND)] = reg_wdata;
      if (reg_addr == adc_ctrl_pkg::OFS_PRESCALER)
      begin
        // restart the divider so the new rate starts on a clean phase
        q_nxt.div     = clamp_div(reg_wdata);
        q_nxt.div_cnt = 10'h000;
      end
    end
    // high phase follows the final count and divisor, so a rate change
    // cuts only a low phase short; a high pulse lasts div >> 1 core cycles, longer when a rate write lands inside it
    q_nxt.clk_out = (q_nxt.div_cnt < (q_nxt.div >> 1));

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    unique case (q_r.st)
      adc_ctrl_pkg::ST_IDLE:
      begin
        // start on any set start bit
        if (reg_wr && reg_addr == adc_ctrl_pkg::OFS_CONTROL)
        begin
          q_nxt.start = reg_wdata[adc_ctrl_pkg::START_LSB +: 3];
          q_nxt.se    = reg_wdata[adc_ctrl_pkg::SE_LSB +: 4];
          if (|reg_wdata[adc_ctrl_pkg::START_LSB +: 3])
          begin
            q_nxt.st     = adc_ctrl_pkg::ST_CONV;
            q_nxt.ch     = new_ch;
            q_nxt.nbits  = new_bits;
            q_nxt.base   = new_base;
            q_nxt.remain = new_total;
            q_nxt.acc    = 18'sh00000;
          end
        end
      end
      adc_ctrl_pkg::ST_CONV:
      begin
        if (tick)
        begin
          // only the last base ticks integrate; earlier ticks let the loop settle
          if (q_r.remain <= q_r.base)
            q_nxt.acc = mod_bit ? q_r.acc + 18'sh00001 : q_r.acc - 18'sh00001;
          q_nxt.remain = q_r.remain - 18'h00001;
          if (q_r.remain == 18'h00001)
            q_nxt.st = adc_ctrl_pkg::ST_DONE;
        end
      end
      adc_ctrl_pkg::ST_DONE:
      begin
        q_nxt.data[q_r.ch] = sat16(scaled);
        q_nxt.start = 3'h0;
        q_nxt.st    = adc_ctrl_pkg::ST_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // data stand only in the cycle after the strobe
    q_nxt.rdata = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == adc_ctrl_pkg::OFS_CONTROL)
        q_nxt.rdata = {(q_r.st != adc_ctrl_pkg::ST_IDLE), 7'h00, q_r.se, 1'b0, q_r.start};
      else if (in_window(reg_addr, adc_ctrl_pkg::OFS_CFG_FIRST, adc_ctrl_pkg::OFS_CFG_SECOND))
        q_nxt.rdata = q_r.cfg_a[2'(reg_addr - adc_ctrl_pkg::OFS_CFG_FIRST)];
      else if (in_window(reg_addr, adc_ctrl_pkg::OFS_CFG_SECOND, adc_ctrl_pkg::OFS_DATA))
        q_nxt.rdata = q_r.cfg_b[2'(reg_addr - adc_ctrl_pkg::OFS_CFG_SECOND)];
      else if (in_window(reg_addr, adc_ctrl_pkg::OFS_DATA, adc_ctrl_pkg::OFS_PRESCALER))
        q_nxt.rdata = q_r.data[2'(reg_addr - adc_ctrl_pkg::OFS_DATA)];
      else if (reg_addr == adc_ctrl_pkg::OFS_PRESCALER)
        q_nxt.rdata = {6'h00, q_r.div};
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q_r.st      <= adc_ctrl_pkg::ST_IDLE;
      q_r.start   <= 3'h0;
      q_r.se      <= 4'h0;
      q_r.cfg_a   <= {3{adc_ctrl_pkg::CFG_RESET}};
      q_r.cfg_b   <= {3{adc_ctrl_pkg::CFG_RESET}};
      q_r.data    <= {3{adc_ctrl_pkg::DATA_RESET}};
      q_r.div     <= adc_ctrl_pkg::PRESC_MIN;
      q_r.div_cnt <= 10'h000;
      q_r.clk_out <= 1'b1;
      q_r.ch      <= adc_ctrl_pkg::CH_ONE;
      q_r.nbits   <= adc_ctrl_pkg::RES_MIN_BITS;
      q_r.base    <= 18'h00000;
      q_r.remain  <= 18'h00000;
      q_r.acc     <= 18'sh00000;
      q_r.rdata   <= 16'h0000;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // cpu clock held off until back in idle
  assign cpu_clk_en  = (q_r.st == adc_ctrl_pkg::ST_IDLE);
  assign reg_rdata   = q_r.rdata;
  assign adc_clk     = q_r.clk_out;
  assign mod_enable  = (q_r.st == adc_ctrl_pkg::ST_CONV);
  // mode outputs follow the channel flop and hold after the run
  assign mod_channel = q_r.ch;
  // single-ended routing only on channels one and two
  assign mod_single_ended_select = is_temp ? 4'h0 : q_r.se;
  assign mod_gain    = act_a[adc_ctrl_pkg::GAIN_LSB +: 5];
  // fixed gain for marked single-ended codes
  assign mod_fixed_gain = !is_temp && (q_r.se != 4'h0) && FIXED_GAIN_SE_MASK[q_r.se];
  assign mod_coarse_offset = act_a[adc_ctrl_pkg::CO_LSB +: 8];
  // reference choice, forced bandgap for temperature
  assign mod_reference_select = (is_temp || ref_raw == 2'h3) ? adc_ctrl_pkg::REF_BANDGAP : ref_raw;
  assign mod_bias_fraction_select = act_b[adc_ctrl_pkg::BIAS_LSB +: 3];

endmodule : adc_ctrl

// File: tb/adc_ctrl_assertions.sv
`timescale 1ns/100ps
module adc_ctrl_assertions (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // converter side
  input wire logic        cpu_clk_en,
  input wire logic        adc_clk,
  input wire logic        mod_enable,
  input wire logic [1:0]  mod_channel,
  input wire logic [3:0]  mod_single_ended_select,
  input wire logic        mod_fixed_gain,
  input wire logic [1:0]  mod_reference_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // halted cycles of the current conversion
  logic [15:0] halt_cnt_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) halt_cnt_r <= 16'h0000;
    else if (cpu_clk_en) halt_cnt_r <= 16'h0000;
    else halt_cnt_r <= halt_cnt_r + 16'h0001;
  sequence s_start;
    reg_wr && reg_addr == adc_ctrl_pkg::OFS_CONTROL && reg_wdata[2:0] != 3'h0 && cpu_clk_en;
  endsequence
  sequence s_done;
    !cpu_clk_en ##1 cpu_clk_en;
  endsequence
  property p_start; s_start |=> !cpu_clk_en && mod_enable; endproperty
  a_start: assert property (p_start) else $error("start write did not halt cpu");
  property p_halt; mod_enable |-> !cpu_clk_en; endproperty
  a_halt: assert property (p_halt) else $error("cpu clock runs during conversion");
  property p_resume; $fell(mod_enable) |-> s_done; endproperty
  a_resume: assert property (p_resume) else $error("cpu clock not back after done cycle");
  property p_min_time; $rose(cpu_clk_en) |-> halt_cnt_r >= 16'h07f8; endproperty
  a_min_time: assert property (p_min_time) else $error("conversion shorter than minimum");
  property p_div; $rose(adc_clk) |-> adc_clk [*2]; endproperty
  a_div: assert property (p_div) else $error("converter clock high too short");
  property p_temp; mod_channel == adc_ctrl_pkg::CH_TEMP |-> mod_reference_select == adc_ctrl_pkg::REF_BANDGAP
    && mod_single_ended_select == 4'h0 && !mod_fixed_gain; endproperty
  a_temp: assert property (p_temp) else $error("temperature channel mode wrong");
  property p_busy; reg_rd && reg_addr == adc_ctrl_pkg::OFS_CONTROL && mod_enable |=> reg_rdata[15]; endproperty
  a_busy: assert property (p_busy) else $error("busy flag low during run");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read cycle");
endmodule : adc_ctrl_assertions
bind adc_ctrl adc_ctrl_assertions chk_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
  .adc_clk(adc_clk), .mod_enable(mod_enable), .mod_channel(mod_channel),
  .mod_single_ended_select(mod_single_ended_select), .mod_fixed_gain(mod_fixed_gain),
  .mod_reference_select(mod_reference_select));

// File: tb/modulator_model.sv
`timescale 1ns/100ps
module modulator_model (
  // clock
  input wire logic core_clk,
  // modulator side
  input wire logic mod_enable,
  input wire logic polarity,
  output logic     mod_bit
);
  // idle line toggles so a stale level never reads as data
  initial mod_bit = 1'b0;
  always @(posedge core_clk)
    mod_bit <= mod_enable ? polarity : ~mod_bit;
endmodule : modulator_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        core_clk, rst, reg_wr, reg_rd, mod_bit, cpu_clk_en, adc_clk, mod_enable, mod_fixed_gain, polarity;
  logic [3:0]  reg_addr, mod_single_ended_select;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [1:0]  mod_channel, mod_reference_select;
  logic [4:0]  mod_gain;
  logic [7:0]  mod_coarse_offset;
  logic [2:0]  mod_bias_fraction_select;
  int          error_cnt, comparisons, dur;
  typedef struct packed { logic [3:0] a; logic [15:0] w; logic [15:0] e; } row_s;
  row_s rows [8] = '{'{4'h1, 16'h1234, 16'h1234}, '{4'h3, 16'hff07, 16'hff07}, '{4'h4, 16'hffff, 16'hffff},
    '{4'h4, 16'h0000, 16'h0000}, '{4'h8, 16'hffff, 16'h0000}, '{4'hf, 16'hffff, 16'h0000},
    '{4'ha, 16'hffff, 16'h0200}, '{4'ha, 16'h0001, 16'h0004}};
  adc_ctrl #(.FIXED_GAIN_SE_MASK(16'hff00)) dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
    .adc_clk(adc_clk), .mod_enable(mod_enable), .mod_channel(mod_channel),
    .mod_single_ended_select(mod_single_ended_select), .mod_gain(mod_gain), .mod_fixed_gain(mod_fixed_gain),
    .mod_coarse_offset(mod_coarse_offset), .mod_reference_select(mod_reference_select),
    .mod_bias_fraction_select(mod_bias_fraction_select), .mod_bit(mod_bit));
  modulator_model far_u (.core_clk(core_clk), .mod_enable(mod_enable), .polarity(polarity), .mod_bit(mod_bit));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  // start, check mode outputs, wait for resume, return halted length
  task automatic run(input logic [15:0] c, input logic p, input logic [15:0] x, input logic [15:0] m);
    repeat (4) @(posedge core_clk);
    polarity <= p;
    wr(adc_ctrl_pkg::OFS_CONTROL, c);
    #1 chk({9'h0, mod_channel, mod_fixed_gain, mod_single_ended_select}, m);
    if (x != 16'h0000)
    begin
      wr(adc_ctrl_pkg::OFS_CONTROL, x);
      rd(adc_ctrl_pkg::OFS_CONTROL, d);
      chk(d & 16'h80f7, c | 16'h8000);
    end
    dur = 1;
    while (cpu_clk_en !== 1'b1 && dur < 20000)
    begin
      @(posedge core_clk);
      #1 dur++;
    end
    if (dur >= 20000)
    begin
      chk(16'hdead, 16'h0000);
      final_report();
    end
    rd(adc_ctrl_pkg::OFS_CONTROL, d);
    chk(d & 16'h8007, 16'h0000);
  endtask : run
  initial
  begin
    {rst, reg_wr, reg_rd, polarity, reg_addr, reg_wdata} = {1'b1, 23'h0};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h7, d);
    chk(d, 16'h0000);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    run(16'h0002, 1'b0, 16'h0000, 16'h0020);
    chk({15'h0, dur >= 2040 && dur <= 2062}, 16'h0001);
    rd(4'h8, d);
    chk(d, 16'h8000);
    rd(4'h7, d);
    chk(d, 16'h0000);
    run(16'h0001, 1'b1, 16'h0000, 16'h0000);
    chk({15'h0, dur >= 4088 && dur <= 4110}, 16'h0001);
    rd(4'h7, d);
    chk(d, 16'h7fff);
    chk({3'h0, mod_gain, mod_coarse_offset}, 16'h1412);
    chk({11'h0, mod_reference_select, mod_bias_fraction_select}, 16'h0000);
    wr(4'h6, 16'h0011);
    run(16'h0054, 1'b1, 16'h0000, 16'h0040);
    rd(4'h9, d);
    chk(d, 16'h7fff);
    chk({3'h0, mod_gain, mod_coarse_offset}, 16'h07ff);
    chk({11'h0, mod_reference_select, mod_bias_fraction_select}, 16'h0011);
    wr(4'h4, 16'h0010);
    run(16'h00f7, 1'b0, 16'h0000, 16'h001f);
    rd(4'h7, d);
    chk(d, 16'h8000);
    chk({11'h0, mod_reference_select, mod_bias_fraction_select}, 16'h0008);
    run(16'h0032, 1'b1, 16'h0001, 16'h0023);
    rd(4'h7, d);
    chk(d, 16'h8000);
    rd(4'h8, d);
    chk(d, 16'h7fff);
    wr(4'ha, 16'h0008);
    run(16'h0002, 1'b0, 16'h0000, 16'h0020);
    chk({15'h0, dur >= 4088 && dur <= 4110}, 16'h0001);
    wr(4'ha, 16'h0004);
    wr(4'h5, 16'h0031);
    run(16'h0002, 1'b0, 16'h0000, 16'h0020);
    chk({15'h0, dur > 2070}, 16'h0001);
    chk({11'h0, mod_reference_select, mod_bias_fraction_select}, 16'h0011);
    wr(adc_ctrl_pkg::OFS_CONTROL, 16'h0001);
    repeat (20) @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk({15'h0, cpu_clk_en}, 16'h0001);
    rd(4'h7, d);
    chk(d, 16'h0000);
    final_report();
  end
endmodule : tb_top
